/* File: design/qdc_pkg.sv */
// constants and register map of the quadrature decoder control block
package qdc_pkg;

    localparam int          QDC_AXES       = 3;
    localparam int          QDC_AW         = 8;

    // register byte offsets
    localparam logic [7:0]  QDC_OFS_CHAN   = 8'h00;
    localparam logic [7:0]  QDC_OFS_IEN    = 8'h04;
    localparam logic [7:0]  QDC_OFS_STAT   = 8'h08;

    // values after reset
    localparam logic [31:0] QDC_CHAN_RST   = 32'h0000_0000;
    localparam logic [31:0] QDC_IEN_RST    = 32'h0000_0000;
    localparam logic [31:0] QDC_STAT_RST   = 32'h0000_0000;

    // field positions, index 0 = x, 1 = y, 2 = z
    localparam int QDC_CHAN_POS [QDC_AXES] = '{0, 4, 8};
    localparam int QDC_UP_POS   [QDC_AXES] = '{25, 27, 29};
    localparam int QDC_DOWN_POS [QDC_AXES] = '{24, 26, 28};
    localparam int QDC_MODE_POS [QDC_AXES] = '{20, 21, 22};
    localparam int QDC_QUA_POS  [QDC_AXES] = '{16, 17, 18};
    localparam int QDC_IDX_POS  [QDC_AXES] = '{10, 11, 12};

    // index interrupt mode encoding
    localparam logic        QDC_IDX_ON_CHANGE = 1'b0;
    localparam logic        QDC_IDX_ON_MATCH  = 1'b1;

    // implemented bits of each register (status bits are set by events, not by writes), all others read zero
    localparam logic [31:0] QDC_CHAN_MASK  = 32'h0000_0111;
    localparam logic [31:0] QDC_IEN_MASK   = 32'h3f77_1c00;
    localparam logic [31:0] QDC_STAT_MASK  = 32'h3f07_1c00;

    typedef enum logic [1:0]
    {
        QDC_SEL_CHAN,
        QDC_SEL_IEN,
        QDC_SEL_STAT,
        QDC_SEL_NONE
    } qdc_sel_t;

endpackage : qdc_pkg

/* File: design/qdc_axis_if.sv */
// per-axis configuration and event bundle between control and selector
`timescale 1ns/100ps
`default_nettype none
interface qdc_axis_if;
    logic chan_on;
    logic idx_mode;
    logic ev_up;
    logic ev_down;
    logic ev_idx_chg;
    logic ev_idx_hit;
    logic ev_qua;
    logic hit_up;
    logic hit_down;
    logic hit_idx;
    logic hit_qua;

    modport ctl
    (
        output chan_on, idx_mode, ev_up, ev_down, ev_idx_chg, ev_idx_hit, ev_qua,
        input  hit_up, hit_down, hit_idx, hit_qua
    );

    modport sel
    (
        input  chan_on, idx_mode, ev_up, ev_down, ev_idx_chg, ev_idx_hit, ev_qua,
        output hit_up, hit_down, hit_idx, hit_qua
    );
endinterface : qdc_axis_if
`default_nettype wire

/* File: design/qdc_axis_sel.sv */
// per-axis event qualifier: channel gate and index mode selection
`timescale 1ns/100ps
`default_nettype none
module qdc_axis_sel
    import qdc_pkg::*;
(
    qdc_axis_if.sel ax
);

    wire idx_pick;

    // a disabled channel produces no events at all
    assign idx_pick    = (ax.idx_mode == QDC_IDX_ON_MATCH) ? ax.ev_idx_hit
                                                           : ax.ev_idx_chg; // RULE4
    assign ax.hit_up   = ax.chan_on & ax.ev_up;
    assign ax.hit_down = ax.chan_on & ax.ev_down;
    assign ax.hit_idx  = ax.chan_on & idx_pick;
    assign ax.hit_qua  = ax.chan_on & ax.ev_qua;

endmodule : qdc_axis_sel
`default_nettype wire

/* File: design/qdc_ctrl.sv */
// quadrature decoder control: apb registers, event status and interrupt
//
// Behaviour
// RULE1: channel enables x,y,z at bits 0,4,8, reset zero
// RULE2: per-axis interrupt enable for upward counter wrap
// RULE3: per-axis interrupt enable for downward counter wrap
// RULE4: index mode: 0 any change, 1 match
// RULE5: per-axis quadrature activity enable, reset zero
// RULE6: only enabled events interrupt; reserved bits read zero
`timescale 1ns/100ps
`default_nettype none
module qdc_ctrl
    import qdc_pkg::*;
#(
    parameter int AXES = QDC_AXES
)
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [QDC_AW-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // one-cycle event pulses from the counting datapath, same clock
    input  wire logic [AXES-1:0]     up_wrap_ev,
    input  wire logic [AXES-1:0]     down_wrap_ev,
    input  wire logic [AXES-1:0]     idx_change_ev,
    input  wire logic [AXES-1:0]     idx_match_ev,
    input  wire logic [AXES-1:0]     qua_activity_ev,
    // configuration towards the datapath, and the interrupt request
    output logic      [AXES-1:0]     chan_on,
    output logic      [AXES-1:0]     idx_mode,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (AXES != QDC_AXES)
    begin : g_bad_axes
        $error("qdc_ctrl: register map holds exactly three axes");
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic qdc_sel_t qdc_decode(input logic [QDC_AW-1:0] a);
        qdc_sel_t s;
        s = QDC_SEL_NONE;
        if (a == QDC_OFS_CHAN)
            s = QDC_SEL_CHAN;
        else if (a == QDC_OFS_IEN)
            s = QDC_SEL_IEN;
        else if (a == QDC_OFS_STAT)
            s = QDC_SEL_STAT;
        return s;
    endfunction : qdc_decode

    logic [31:0] chan_r;
    logic [31:0] chan_nxt;
    logic [31:0] ien_r;
    logic [31:0] ien_nxt;
    logic [31:0] stat_r;
    logic [31:0] stat_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        irq_r;
    logic        irq_nxt;

    qdc_sel_t    sel;
    wire         setup_ph;
    wire         done_ph;
    wire         wr_done;
    wire         rd_done;
    wire         wr_chan;
    wire         wr_ien;
    wire         rd_stat;
    wire  [31:0] rd_mux;
    wire  [31:0] set_bits;
    wire  [31:0] clr_bits;

    assign sel      = qdc_decode(paddr);
    assign setup_ph = psel & ~penable;
    // pready is raised only in the first access cycle: one wait-free access
    assign done_ph  = psel & penable & pready_r;
    assign wr_done  = done_ph & pwrite & ~pslverr_r;
    assign rd_done  = done_ph & ~pwrite & ~pslverr_r;
    assign wr_chan  = wr_done & (sel == QDC_SEL_CHAN);
    assign wr_ien   = wr_done & (sel == QDC_SEL_IEN);
    assign rd_stat  = rd_done & (sel == QDC_SEL_STAT);

    ////////////////////////////////////////////////////////////////////////
    // per-axis event qualification

    qdc_axis_if ax_if [AXES] ();

    logic [31:0] ev_bits [AXES+1];

    assign ev_bits[0] = 32'h0000_0000;

    for (genvar g = 0; g < AXES; g++)
    begin : g_axis
        assign ax_if[g].chan_on    = chan_r[QDC_CHAN_POS[g]];   // RULE1
        assign ax_if[g].idx_mode   = ien_r[QDC_MODE_POS[g]];    // RULE4
        assign ax_if[g].ev_up      = up_wrap_ev[g];
        assign ax_if[g].ev_down    = down_wrap_ev[g];
        assign ax_if[g].ev_idx_chg = idx_change_ev[g];
        assign ax_if[g].ev_idx_hit = idx_match_ev[g];
        assign ax_if[g].ev_qua     = qua_activity_ev[g];

        qdc_axis_sel u_sel
        (
            .ax (ax_if[g])
        );

        wire [31:0] one_axis;

        assign one_axis = (32'(ax_if[g].hit_up)   << QDC_UP_POS[g])
                        | (32'(ax_if[g].hit_down) << QDC_DOWN_POS[g])
                        | (32'(ax_if[g].hit_idx)  << QDC_IDX_POS[g])
                        | (32'(ax_if[g].hit_qua)  << QDC_QUA_POS[g]);
        assign ev_bits[g+1] = ev_bits[g] | one_axis;
    end

    assign set_bits = ev_bits[AXES] & QDC_STAT_MASK;

    ////////////////////////////////////////////////////////////////////////
    // read path

    // read data is latched in the setup cycle; only those bits are cleared,
    // so an event landing between setup and access is not lost
    assign rd_mux = (sel == QDC_SEL_CHAN) ? (chan_r & QDC_CHAN_MASK)
                  : (sel == QDC_SEL_IEN)  ? (ien_r  & QDC_IEN_MASK)
                  : (sel == QDC_SEL_STAT) ? (stat_r & QDC_STAT_MASK)
                  : 32'h0000_0000;                              // RULE6
    assign clr_bits = rd_stat ? prdata_r : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        chan_nxt    = chan_r;
        ien_nxt     = ien_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        if (wr_chan)
            chan_nxt = pwdata & QDC_CHAN_MASK;                  // RULE1
        if (wr_ien)
            ien_nxt = pwdata & QDC_IEN_MASK;                    // RULE2 RULE3 RULE5
        if (setup_ph)
        begin
            prdata_nxt  = pwrite ? 32'h0000_0000 : rd_mux;
            pready_nxt  = 1'b1;
            pslverr_nxt = (sel == QDC_SEL_NONE);
        end
    end

    // set wins over the read clear
    assign stat_nxt = (stat_r & ~clr_bits) | set_bits;

    // gated by the enable register, which doubles as the interrupt mask
    assign irq_nxt  = |(stat_nxt & ien_r & QDC_STAT_MASK);     // RULE6 RULE2 RULE3 RULE5

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_r    <= QDC_CHAN_RST;
            ien_r     <= QDC_IEN_RST;
            stat_r    <= QDC_STAT_RST;
        end
        else
        begin
            chan_r    <= chan_nxt;
            ien_r     <= ien_nxt;
            stat_r    <= stat_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r     <= 1'b0;
        end
        else
        begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r     <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    for (genvar g = 0; g < AXES; g++)
    begin : g_out
        assign chan_on[g]  = chan_r[QDC_CHAN_POS[g]];
        assign idx_mode[g] = ien_r[QDC_MODE_POS[g]];
    end

endmodule : qdc_ctrl
`default_nettype wire

/* File: sim/qdc_ctrl_asserts.sv */
// port assertions for the decoder control block
`timescale 1ns/100ps
`default_nettype none
module qdc_ctrl_asserts
    import qdc_pkg::*;
#(
    parameter int AXES = QDC_AXES
)
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [QDC_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [AXES-1:0]   up_wrap_ev,
    input wire logic [AXES-1:0]   down_wrap_ev,
    input wire logic [AXES-1:0]   idx_change_ev,
    input wire logic [AXES-1:0]   idx_match_ev,
    input wire logic [AXES-1:0]   qua_activity_ev,
    input wire logic [AXES-1:0]   chan_on,
    input wire logic [AXES-1:0]   idx_mode,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire setup = psel && !penable;
    wire wr    = psel && penable && pready && pwrite && !pslverr;
    wire ienw  = wr && paddr == QDC_OFS_IEN;
    wire anyev = |{up_wrap_ev, down_wrap_ev, idx_change_ev, idx_match_ev, qua_activity_ev};
    wire mapped = paddr inside {QDC_OFS_CHAN, QDC_OFS_IEN, QDC_OFS_STAT};
    a_ready_next: assert property (setup |=> pready)
        else $error("pready late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready too long");
    a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_reserved_zero: assert property (pready && !pwrite |-> (prdata & 32'hc088_e2ee) == 32'h0)
        else $error("reserved bit read one");
    a_chan_write: assert property (wr && paddr == QDC_OFS_CHAN
        |=> chan_on == {pwdata[8], pwdata[4], pwdata[0]})
        else $error("channel enable not written");
    a_chan_hold: assert property (!$stable(chan_on) |-> $past(wr && paddr == QDC_OFS_CHAN))
        else $error("channel enable changed alone");
    a_mode_write: assert property (ienw |=> idx_mode == pwdata[22:20])
        else $error("index mode not written");
    a_irq_cause: assert property ($rose(irq) |-> $past(anyev) || $past(anyev, 2)
        || $past(ienw) || $past(ienw, 2))
        else $error("irq without cause");
endmodule : qdc_ctrl_asserts
bind qdc_ctrl qdc_ctrl_asserts #(.AXES(AXES)) u_qdc_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .up_wrap_ev(up_wrap_ev),
    .down_wrap_ev(down_wrap_ev), .idx_change_ev(idx_change_ev), .idx_match_ev(idx_match_ev),
    .qua_activity_ev(qua_activity_ev), .chan_on(chan_on), .idx_mode(idx_mode), .irq(irq));
`default_nettype wire

/* File: sim/test_quadrature_decoder_control.sv */
// self-checking bench for the decoder control block
`timescale 1ns/100ps
`default_nettype none
module test_quadrature_decoder_control;
    import qdc_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] evs;
    logic [2:0]  chan_on, idx_mode;
    int          failures, checks;
    qdc_ctrl DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .up_wrap_ev(evs[2:0]), .down_wrap_ev(evs[5:3]),
        .idx_change_ev(evs[8:6]), .idx_match_ev(evs[11:9]), .qua_activity_ev(evs[14:12]),
        .chan_on(chan_on), .idx_mode(idx_mode), .irq(irq));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // waits for pready as long as it takes; only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        // settle point: register outputs updated by this transfer are visible
        @(negedge clk);
    endtask : apb
    task pulse(input int b);
        @(posedge clk);
        evs[b] <= 1;
        @(posedge clk);
        evs[b] <= 0;
        @(posedge clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, QDC_OFS_CHAN, 0); chk(rd, 32'h0);
        apb(0, QDC_OFS_IEN, 0); chk(rd, 32'h0);
        apb(0, 8'h0c, 0); chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task t_chan;
        apb(1, QDC_OFS_CHAN, 32'hffff_ffff); apb(0, QDC_OFS_CHAN, 0);
        chk(rd, 32'h111);
        apb(1, QDC_OFS_CHAN, 32'h10); chk(chan_on, 3'h2);
        pulse(0); apb(0, QDC_OFS_STAT, 0); chk(rd, 32'h0);
        apb(1, QDC_OFS_CHAN, 32'h111); chk(chan_on, 3'h7);
        $display("channel test done");
    endtask : t_chan
    // disabled events must record but stay quiet
    task t_wrap;
        int ax, p, e;
        apb(1, QDC_OFS_IEN, 32'hffff_ffff); chk(idx_mode, 3'h7);
        apb(0, QDC_OFS_IEN, 0);
        chk(rd, 32'h3f77_1c00);
        for (int i = 0; i < 9; i++)
        begin
            ax = i % 3;
            p = i < 3 ? QDC_UP_POS[ax] : i < 6 ? QDC_DOWN_POS[ax] : QDC_QUA_POS[ax];
            e = i < 6 ? i : i + 6;
            apb(1, QDC_OFS_IEN, 0); pulse(e); chk(irq, 0);
            apb(0, QDC_OFS_STAT, 0); chk(rd, 32'h1 << p);
            apb(1, QDC_OFS_IEN, 32'h1 << p); pulse(e); chk(irq, 1);
            apb(0, QDC_OFS_STAT, 0); @(posedge clk); chk(irq, 0);
        end
        $display("wrap test done");
    endtask : t_wrap
    task t_index;
        apb(1, QDC_OFS_IEN, 32'h400); chk(idx_mode, 3'h0);
        pulse(9); chk(irq, 0); pulse(6); chk(irq, 1);
        apb(0, QDC_OFS_STAT, 0); chk(rd, 32'h400);
        apb(1, QDC_OFS_IEN, 32'h10_0400); chk(idx_mode, 3'h1);
        pulse(6); chk(irq, 0); pulse(9); chk(irq, 1);
        apb(0, QDC_OFS_STAT, 0); chk(rd, 32'h400);
        $display("index test done");
    endtask : t_index
    task conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; evs = 0;
        failures = 0; checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1;
        t_reset; t_chan; t_wrap; t_index;
        conclude;
    end
    initial
    begin
        #100000;
        failures++;
        conclude;
    end
endmodule : test_quadrature_decoder_control
`default_nettype wire
